// ===== rtl/rta_pkg.sv
// Package of constants and types for the slow real-time timer with alarm
package rta_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 32;
  localparam int SNAP_BYTES = 6;
  localparam int MATCH_BYTES = 4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLOW_DIV_DEFAULT = 1000;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SNAP_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MATCH_BASE = 8'h18;

  localparam int BIT_OSC_EN = 7;
  localparam int BIT_LOST_CLK_EN = 6;
  localparam int BIT_OSC_FAIL = 5;
  localparam int BIT_RUN = 4;
  localparam int BIT_ALARM_EN = 3;
  localparam int BIT_ALARM_FLAG = 2;
  localparam int BIT_LOAD_REQ = 1;
  localparam int BIT_SNAP_REQ = 0;

  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h0000_0001;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rta_req_type;

  typedef struct packed {
    logic irq;
    logic wake;
    logic rst;
  } rta_alarm_out_type;

  typedef struct packed {
    logic osc_enable;
    logic bias_enable;
    logic lost_clock_detect_enable;
  } rta_osc_ctl_type;

  // Auto-reset sequence, Gray coded along idle -> alarm -> clear
  typedef enum logic [1:0] {
    AR_IDLE = 2'b00,
    AR_ALARM = 2'b01,
    AR_CLEAR = 2'b11
  } rta_ar_state_type;
endpackage : rta_pkg

// ===== rtl/rta_sync2.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module rta_sync2 (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : rta_sync2

// ===== rtl/rta_tick_div.sv
// Divider making the one-cycle slow timer tick from the system clock
`timescale 1ns/100ps
module rta_tick_div #(
  parameter int DIV = 1000
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic enable,
  output logic tick_q
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_q;

  if (DIV < 2)
  begin : g_chk
    $error("Divider must be at least 2");
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (!enable)
    begin
      // Stopped oscillator gives no ticks
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
    end
  end
endmodule : rta_tick_div

// ===== rtl/rta_timer_alarm.sv
// Slow real-time timer with equality alarm, auto-reset and register port
`timescale 1ns/100ps
module rta_timer_alarm
  import rta_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_DIV_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire rta_req_type req,
  input wire logic osc_fail_in,
  output logic [DATA_W-1:0] rd_data_q,
  output rta_alarm_out_type alarm_out_q,
  output rta_osc_ctl_type osc_ctl_q
);
  logic tick;
  logic fail_sync;
  logic [COUNT_W-1:0] cnt_q;
  logic [COUNT_W-1:0] cnt_d;
  logic [DATA_W-1:0] snap_q [SNAP_BYTES];
  logic [DATA_W-1:0] match_q [MATCH_BYTES];
  logic [COUNT_W-1:0] snap_word;
  logic [COUNT_W-1:0] match_word;
  logic run_q;
  logic alarm_en_q;
  logic auto_reset_q;
  logic alarm_flag_q;
  logic load_req_q;
  logic snap_req_q;
  logic osc_fail_q;
  logic ctrl_wr;
  logic busy;
  logic hit;
  logic [COUNT_W-1:0] flag_age_q;
  rta_ar_state_type ar_q;

  if (SLOW_DIV < 2)
  begin : g_chk
    $error("SLOW_DIV must be at least 2");
  end

  // Slow cycles are enable pulses on the system clock, so requests and
  // the alarm flag live in one domain and need no crossing
  rta_tick_div #(
    .DIV(SLOW_DIV)
  ) u_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .enable(osc_ctl_q.osc_enable),
    .tick_q(tick)
  );

  rta_sync2 u_fail_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in(osc_fail_in),
    .sync_out(fail_sync)
  );

  assign ctrl_wr = req.wr && (req.addr == ADDR_CTRL);
  assign busy = load_req_q || snap_req_q;
  // An event needs the count to move onto the compare value, so a stopped
  // counter parked on it cannot hold the flag beyond one slow cycle
  assign hit = alarm_en_q && (cnt_d == match_word) && (cnt_d != cnt_q);
  for (genvar i = 0; i < MATCH_BYTES; i++)
  begin : g_words
    assign snap_word[i*DATA_W +: DATA_W] = snap_q[i];
    assign match_word[i*DATA_W +: DATA_W] = match_q[i];
  end

  // Set has priority over auto-reset, which has priority over counting
  always_comb
  begin
    cnt_d = cnt_q;
    if (tick)
    begin
      if (load_req_q)
        cnt_d = snap_word;
      else if (ar_q == AR_CLEAR)
        cnt_d = COUNT_RESET;
      else if (run_q)
        cnt_d = cnt_q + COUNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= COUNT_RESET;
    else
      cnt_q <= cnt_d;
  end

  // Control bits written by software
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_ctl_q <= '0;
      run_q <= 1'b0;
      alarm_en_q <= 1'b0;
      auto_reset_q <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      osc_ctl_q.osc_enable <= req.wdata[BIT_OSC_EN];
      osc_ctl_q.bias_enable <= req.wdata[BIT_OSC_EN];
      osc_ctl_q.lost_clock_detect_enable <= req.wdata[BIT_LOST_CLK_EN];
      run_q <= req.wdata[BIT_RUN];
      alarm_en_q <= req.wdata[BIT_ALARM_EN];
      auto_reset_q <= req.wdata[BIT_ALARM_FLAG];
    end
  end

  // Requests: software sets, hardware clears on the completing tick.
  // A new write of one in the completing cycle wins and starts another.
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      load_req_q <= 1'b0;
      snap_req_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr && req.wdata[BIT_LOAD_REQ])
        load_req_q <= 1'b1;
      else if (tick)
        load_req_q <= 1'b0;
      if (ctrl_wr && req.wdata[BIT_SNAP_REQ])
        snap_req_q <= 1'b1;
      else if (tick && !load_req_q)
        snap_req_q <= 1'b0;
    end
  end

  // Snapshot bytes: capture fills the low four, software writes are
  // dropped while a transfer is pending so it sees a stable value
  for (genvar i = 0; i < SNAP_BYTES; i++)
  begin : g_snap
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
        snap_q[i] <= BYTE_RESET;
      else if (i < MATCH_BYTES && tick && snap_req_q && !load_req_q)
        snap_q[i] <= cnt_q[(i % MATCH_BYTES)*DATA_W +: DATA_W];
      else if (req.wr && !busy && req.addr == ADDR_SNAP_BASE + ADDR_W'(i))
        snap_q[i] <= req.wdata;
    end
  end

  for (genvar i = 0; i < MATCH_BYTES; i++)
  begin : g_match
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
      if (!arst_n)
        match_q[i] <= BYTE_RESET;
      else if (req.wr && req.addr == ADDR_MATCH_BASE + ADDR_W'(i))
        match_q[i] <= req.wdata;
    end
  end

  // Alarm flag follows equality of the new count, so it drops on the
  // next tick; the same compare matches again after a wrap, an auto-reset zeroing or a set
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      alarm_flag_q <= 1'b0;
    else if (ctrl_wr && !req.wdata[BIT_ALARM_EN])
      alarm_flag_q <= 1'b0;
    else if (tick)
      alarm_flag_q <= hit;
  end

  // Auto-reset sequencing driven by the alarm hit and stepped on each tick
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      ar_q <= AR_IDLE;
    else if (tick)
    begin
      case (ar_q)
        AR_IDLE: ar_q <= hit ? AR_ALARM : AR_IDLE;
        AR_ALARM: ar_q <= auto_reset_q ? AR_CLEAR : AR_IDLE;
        AR_CLEAR: ar_q <= AR_IDLE;
        default: ar_q <= AR_IDLE;
      endcase
    end
  end

  // Failure flag: hardware set wins over a software clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      osc_fail_q <= 1'b0;
    else if (fail_sync && osc_ctl_q.lost_clock_detect_enable)
      osc_fail_q <= 1'b1;
    else if (ctrl_wr && !req.wdata[BIT_OSC_FAIL])
      osc_fail_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      alarm_out_q <= '0;
    else
      alarm_out_q <= '{irq: alarm_flag_q, wake: alarm_flag_q, rst: alarm_flag_q};
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_q <= BYTE_RESET;
    else if (req.rd)
    begin
      rd_data_q <= BYTE_RESET;
      if (req.addr == ADDR_CTRL)
      begin
        rd_data_q[BIT_OSC_EN] <= osc_ctl_q.osc_enable;
        rd_data_q[BIT_LOST_CLK_EN] <= osc_ctl_q.lost_clock_detect_enable;
        rd_data_q[BIT_OSC_FAIL] <= osc_fail_q;
        rd_data_q[BIT_RUN] <= run_q;
        rd_data_q[BIT_ALARM_EN] <= alarm_en_q;
        rd_data_q[BIT_ALARM_FLAG] <= alarm_flag_q;
        rd_data_q[BIT_LOAD_REQ] <= load_req_q;
        rd_data_q[BIT_SNAP_REQ] <= snap_req_q;
      end
      for (int i = 0; i < SNAP_BYTES; i++)
        if (req.addr == ADDR_SNAP_BASE + ADDR_W'(i))
          rd_data_q <= snap_q[i];
      for (int i = 0; i < MATCH_BYTES; i++)
        if (req.addr == ADDR_MATCH_BASE + ADDR_W'(i))
          rd_data_q <= match_q[i];
    end
  end

  // Helper for the checks: cycles the flag has stood with the oscillator on
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      flag_age_q <= COUNT_RESET;
    else
      flag_age_q <= (alarm_flag_q && osc_ctl_q.osc_enable) ? flag_age_q + COUNT_ONE : COUNT_RESET;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_count_step: assert property (tick && run_q && !load_req_q && ar_q != AR_CLEAR
    |=> cnt_q == $past(cnt_q) + COUNT_ONE)
    else $error("Counter did not advance on a running tick");
  a_count_hold: assert property (!tick |=> $stable(cnt_q))
    else $error("Counter moved without a tick");
  a_load_copy: assert property (tick && load_req_q && !ctrl_wr
    |=> cnt_q == $past(snap_word) && !load_req_q)
    else $error("Set transfer did not load the counter");
  a_req_set: assert property (ctrl_wr && req.wdata[BIT_LOAD_REQ]
    |=> load_req_q)
    else $error("Set request bit did not take the write");
  a_snap_copy: assert property (tick && snap_req_q && !load_req_q && !ctrl_wr
    |=> snap_word == $past(cnt_q) && !snap_req_q)
    else $error("Capture did not copy the counter");
  a_auto_arm: assert property (tick && ar_q == AR_ALARM && auto_reset_q
    |=> ar_q == AR_CLEAR)
    else $error("Auto-reset did not arm when the alarm fell");
  a_auto_zero: assert property (tick && ar_q == AR_CLEAR && !load_req_q
    |=> cnt_q == COUNT_RESET)
    else $error("Auto-reset did not zero the counter");
  a_flag_short: assert property (alarm_flag_q && tick && cnt_d != match_word
    |=> !alarm_flag_q)
    else $error("Alarm flag outlived one slow cycle");
  // Restarting the oscillator restarts the divider, so allow one full period
  a_flag_width: assert property (alarm_flag_q |-> flag_age_q <= COUNT_W'(SLOW_DIV))
    else $error("Alarm flag stood longer than one slow cycle");
  a_flag_match: assert property (tick && alarm_en_q && !ctrl_wr
    && cnt_d == match_word && cnt_d != cnt_q
    |=> alarm_flag_q ##1 alarm_out_q.irq && alarm_out_q.wake && alarm_out_q.rst)
    else $error("Counter match did not raise the alarm");
  a_alarm_pins: assert property (alarm_out_q.irq == $past(alarm_flag_q)
    && alarm_out_q.wake == alarm_out_q.irq && alarm_out_q.rst == alarm_out_q.irq)
    else $error("Alarm outputs do not follow the flag");
  a_flag_clear: assert property (ctrl_wr && !req.wdata[BIT_ALARM_EN]
    |=> !alarm_flag_q ##1 !alarm_out_q.irq)
    else $error("Disabling alarm left the flag set");
  a_snap_guard: assert property (busy && req.wr && !tick
    |=> $stable(snap_word) && $stable(snap_q[4]) && $stable(snap_q[5]))
    else $error("Snapshot changed by a write during a transfer");
  a_fail_sticky: assert property (osc_fail_q && !(ctrl_wr && !req.wdata[BIT_OSC_FAIL])
    |=> osc_fail_q)
    else $error("Failure flag dropped without a software clear");
  a_flag_read: assert property (req.rd && req.addr == ADDR_CTRL
    |=> rd_data_q[BIT_ALARM_FLAG] == $past(alarm_flag_q)
        && rd_data_q[BIT_LOAD_REQ] == $past(load_req_q))
    else $error("Control read does not show flag and request state");
  a_osc_enable: assert property (ctrl_wr
    |=> osc_ctl_q.osc_enable == $past(req.wdata[BIT_OSC_EN]) && osc_ctl_q.bias_enable
        == osc_ctl_q.osc_enable)
    else $error("Oscillator enable does not follow bit 7");

  c_load_done: cover property (load_req_q && tick ##1 !load_req_q);
  c_snap_done: cover property (snap_req_q && tick ##1 !snap_req_q);
  c_auto_reset: cover property (ar_q == AR_CLEAR && tick);
  c_osc_fail: cover property ($rose(osc_fail_q));
  c_flag_drop: cover property (alarm_flag_q && tick ##1 !alarm_flag_q);
endmodule : rta_timer_alarm

// ===== bench/test_rta_timer_alarm.sv
// Register-level testbench for the slow timer with alarm
`timescale 1ns/100ps
module test_rta_timer_alarm;
  import rta_pkg::*;
  // Short slow period keeps alarm runs brief
  localparam int DIV = 8;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  rta_req_type req = '0;
  logic osc_fail_in = 1'b0;
  logic [DATA_W-1:0] rd_data_q;
  rta_alarm_out_type alarm_out_q;
  rta_osc_ctl_type osc_ctl_q;
  int error_cnt = 0;
  int checked = 0;
  logic [DATA_W-1:0] rv;
  logic [COUNT_W-1:0] word;
  int n;

  rta_timer_alarm #(.SLOW_DIV(DIV)) DUT (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .req(req),
    .osc_fail_in(osc_fail_in),
    .rd_data_q(rd_data_q),
    .alarm_out_q(alarm_out_q),
    .osc_ctl_q(osc_ctl_q)
  );

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic check(input logic [COUNT_W-1:0] seen, input logic [COUNT_W-1:0] exp,
                       input string what);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask : wr_reg

  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    d = rd_data_q;
  endtask : rd_reg

  task automatic wr_word(input logic [ADDR_W-1:0] base, input logic [COUNT_W-1:0] w);
    for (int i = 0; i < 4; i++)
      wr_reg(base + ADDR_W'(i), w[8*i +: 8]);
  endtask : wr_word

  task automatic rd_word(output logic [COUNT_W-1:0] w);
    logic [DATA_W-1:0] b;
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(ADDR_SNAP_BASE + ADDR_W'(i), b);
      w[8*i +: 8] = b;
    end
  endtask : rd_word

  task automatic wait_clear(input int b);
    logic [DATA_W-1:0] v;
    for (int i = 0; i < 40; i++)
    begin
      rd_reg(ADDR_CTRL, v);
      if (v[b] === 1'b0)
        return;
    end
    check(1'h1, 1'h0, "request bit never cleared");
    results();
  endtask : wait_clear

  task automatic wait_irq();
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (alarm_out_q.irq === 1'b1)
        return;
    end
    check(1'h0, 1'h1, "alarm never raised");
    results();
  endtask : wait_irq

  initial
  begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd_reg(ADDR_CTRL, rv);
    check(rv, 8'h00, "control after reset");
    check(32'(osc_ctl_q), 3'h0, "osc controls after reset");
    rd_reg(8'h00, rv);
    check(rv, 8'h00, "unmapped read");
    // Oscillator off: the set request waits, so byte writes must be dropped
    wr_word(ADDR_SNAP_BASE, 32'h1234_5678);
    wr_reg(ADDR_CTRL, 8'h02);
    rd_reg(ADDR_CTRL, rv);
    check(rv[BIT_LOAD_REQ], 1'h1, "set request pending");
    wr_reg(ADDR_SNAP_BASE, 8'hAA);
    rd_reg(ADDR_SNAP_BASE, rv);
    check(rv, 8'h78, "byte write during pending set");
    wr_reg(ADDR_CTRL, 8'h82);
    wait_clear(BIT_LOAD_REQ);
    check(32'(osc_ctl_q), 3'h6, "osc and bias enabled");
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(ADDR_CTRL, 8'h81);
      wait_clear(BIT_SNAP_REQ);
      rd_word(word);
      check(word, 32'h1234_5678, "stopped count snapshot");
      repeat (3 * DIV) @(posedge clk_sys);
    end
    // Set and capture while running, across the 32-bit wrap
    wr_word(ADDR_SNAP_BASE, 32'hFFFF_FFFF);
    wr_reg(ADDR_CTRL, 8'h92);
    wait_clear(BIT_LOAD_REQ);
    wr_reg(ADDR_CTRL, 8'h91);
    wait_clear(BIT_SNAP_REQ);
    rd_word(word);
    check(32'(word + 32'h0000_0001 <= 32'h0000_0003), 1'h1, "running snapshot");
    // Auto-reset alarm meant for 0x12, so the compare is set two below it
    wr_reg(ADDR_CTRL, 8'h80);
    wr_word(ADDR_SNAP_BASE, 32'h0000_0000);
    wr_reg(ADDR_CTRL, 8'h82);
    wait_clear(BIT_LOAD_REQ);
    wr_word(ADDR_MATCH_BASE, 32'h0000_0012 - 32'h0000_0002);
    wr_reg(ADDR_CTRL, 8'h9C);
    wait_irq();
    check({alarm_out_q.wake, alarm_out_q.rst}, 2'h3, "wake and reset outputs");
    for (n = 1; n < 4 * DIV; n++)
    begin
      @(posedge clk_sys);
      #1;
      if (alarm_out_q.irq !== 1'b1)
        break;
    end
    check(n, DIV, "alarm width");
    // Stop between the zeroing tick and the next one
    repeat (DIV + 3) @(posedge clk_sys);
    wr_reg(ADDR_CTRL, 8'h81);
    wait_clear(BIT_SNAP_REQ);
    rd_word(word);
    check(word, 32'h0000_0000, "count after auto-reset");
    // Plain alarm at 8, auto-reset off, then disabled while the flag stands
    wr_word(ADDR_MATCH_BASE, 32'h0000_0008);
    wr_reg(ADDR_CTRL, 8'h98);
    wait_irq();
    rd_reg(ADDR_CTRL, rv);
    check(rv[BIT_ALARM_FLAG], 1'h1, "flag read during alarm");
    wr_reg(ADDR_CTRL, 8'h90);
    repeat (2) @(posedge clk_sys);
    #1;
    check(alarm_out_q.irq, 1'h0, "alarm cleared by disable");
    repeat (2 * DIV) @(posedge clk_sys);
    wr_reg(ADDR_CTRL, 8'h81);
    wait_clear(BIT_SNAP_REQ);
    rd_word(word);
    check(32'(word >= 32'h0000_0009), 1'h1, "no auto-reset when written 0");
    // Perpetual timebase: compare moved past the wrap by 32-bit addition
    wr_word(ADDR_SNAP_BASE, 32'hFFFF_FFFC);
    wr_reg(ADDR_CTRL, 8'h82);
    wait_clear(BIT_LOAD_REQ);
    word = 32'hFFFF_FFFC + 32'h0000_0006;
    wr_word(ADDR_MATCH_BASE, word);
    wr_reg(ADDR_CTRL, 8'h98);
    wait_irq();
    // Stopped at once, so the next tick holds the count that matched
    wr_reg(ADDR_CTRL, 8'h81);
    wait_clear(BIT_SNAP_REQ);
    rd_word(word);
    check(word, 32'h0000_0002, "count at wrapped alarm");
    // Failure flag: set by the detector, cleared by a software write of 0
    wr_reg(ADDR_CTRL, 8'hC0);
    osc_fail_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    osc_fail_in <= 1'b0;
    check(osc_ctl_q.lost_clock_detect_enable, 1'h1, "detector enable");
    rd_reg(ADDR_CTRL, rv);
    check(rv[BIT_OSC_FAIL], 1'h1, "failure flag set");
    wr_reg(ADDR_CTRL, 8'hC0);
    rd_reg(ADDR_CTRL, rv);
    check(rv[BIT_OSC_FAIL], 1'h0, "failure flag cleared");
    results();
  end
endmodule : test_rta_timer_alarm
